/* File: rtl/cam_cmd_decoder.sv */
/*
  Camera remote command decoder: APB slave taking ground commands, four
  reversible motor axes and three latched switched functions with
  override and power interlocks.
  Assumes APB master in the CLK_I domain; limit, override and supply
  inputs already synchronous to CLK_I.
*/
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Each axis decodes forward, reverse and stop: twelve motor commands.
// - Motor commands accepted in any order, including direct reversal.
// - Several axes may run together, each with its own state.
// - Hitting an end limit stops that axis like a stop command.
// - At a limit, commands driving further in are ignored until reversed.
// - No axis runs while camera power is off.
// - After any power loss every axis is stopped when power returns.
// - Each switched function has set and clear commands; state latches.
// - Light mode latch picks peak (100 percent) or average (60 percent).
// - Subcarrier commands set or clear the voice subcarrier enable.
// - Power on also sets subcarrier; power drives transmitter in remote mode.
// - Power off is standby: only power on is acted upon.
// - Override switch ends force power and light latches; centre is remote.
// - Override acts only while held; release returns control to commands.
// - Power on by override does not force subcarrier on.
// - Latches keep their state across any power interruption.
// - Iris covers 123 degrees within 13.1 seconds running continuously.
module cam_cmd_decoder
  import cam_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Limit switches, one per axis per direction (pan tilt zoom iris)
  input  wire logic [3:0]  LIM_FWD_I,
  input  wire logic [3:0]  LIM_REV_I,
  // Assembly supply present (low during an interruption)
  input  wire logic        SUPPLY_OK_I,
  // Override switches: held at an extreme end
  input  wire logic        OVR_PWR_ON_I,
  input  wire logic        OVR_PWR_OFF_I,
  input  wire logic        OVR_PEAK_I,
  input  wire logic        OVR_AVERAGE_I,
  // Motor drives
  output logic      [3:0]  MOTOR_RUN_O,
  output logic      [3:0]  MOTOR_REV_O,
  // Switched functions
  output logic             CAMERA_POWER_O,
  output logic             PEAK_LIGHT_MODE_O,
  output logic             SUBCARRIER_EN_O,
  output logic             XMIT_CTRL_O
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic        power;      // Camera power latch
    logic        peak;       // 1: peak_light_mode, 0: average_light_mode
    logic        sc;         // Voice subcarrier latch
    logic        tv_remote;  // Relay unit in tv remote mode
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [3:0]  run;
    logic [3:0]  rev;
    logic        xmit;
    logic        cam_pwr;
    logic        peak_o;
    logic        sc_o;
  } state_t;

  state_t st;
  state_t next_st;

  // Axis directions from the axis instances
  dir_t dir [NUM_AXES];

  // Command pulses per axis
  logic [3:0] ax_fwd;
  logic [3:0] ax_rev;
  logic [3:0] ax_stop;

  // Motors only see power when the latch after override is on and the supply is present
  logic motor_power;

  // ==========================================================================
  // Address decode helper, used by both read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == CMD_OFS) || (a == STATUS_OFS) ||
                (a == LIMIT_OFS) || (a == CTRL_OFS);
  endfunction : is_mapped

  // Zero-wait APB: the access phase completes in its first cycle
  logic wr_access;
  logic cmd_wr;
  logic [4:0] cmd;
  assign wr_access = PSEL_I && PENABLE_I && PWRITE_I;
  assign cmd_wr    = wr_access && (PADDR_I == CMD_OFS);
  assign cmd       = PWDATA_I[4:0];

  // Effective power after override; override acts only while held
  logic eff_power;
  always_comb begin
    eff_power = st.power;
    if (OVR_PWR_ON_I) begin
      eff_power = 1'b1;
    end else if (OVR_PWR_OFF_I) begin
      eff_power = 1'b0;
    end
  end
  assign motor_power = eff_power && SUPPLY_OK_I;

  // ==========================================================================
  // Motor command decode: codes 01..0C map to axis*3 + op
  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++) begin : g_axis
      localparam logic [4:0] BASE = 5'(CMD_AXIS_BASE + 5'(3 * g));
      // Standby: forward and reverse commands are dropped while power is off; stop passes
      assign ax_fwd[g]  = cmd_wr && motor_power &&
                          cmd == 5'(BASE + 5'(OP_FWD));
      assign ax_rev[g]  = cmd_wr && motor_power &&
                          cmd == 5'(BASE + 5'(OP_REV));
      assign ax_stop[g] = cmd_wr && cmd == 5'(BASE + 5'(OP_STOP));

      // Independent run state per axis
      cam_axis u_axis (
        .clk_i     (CLK_I),
        .rst_n_i   (RST_N_I),
        .fwd_i     (ax_fwd[g]),
        .rev_i     (ax_rev[g]),
        .stop_i    (ax_stop[g]),
        .power_i   (motor_power),
        .lim_fwd_i (LIM_FWD_I[g]),
        .lim_rev_i (LIM_REV_I[g]),
        .dir_o     (dir[g])
      );
      // Reverse end mirrors the forward check kept inside the axis
      a_rev_limit: assert property (
        @(posedge CLK_I) disable iff (!RST_N_I)
        LIM_REV_I[g] |=> ##1 !(MOTOR_RUN_O[g] && MOTOR_REV_O[g]))
        else $error("axis ran into reverse limit");
    end
  endgenerate

  // ==========================================================================
  // Latches, outputs and APB answer
  always_comb begin
    next_st = st;
    // Ground commands on the switched functions
    if (cmd_wr) begin
      if (cmd == CMD_PWR_ON) begin
        next_st.power = 1'b1;
        next_st.sc    = 1'b1;
      end else if (cmd == CMD_PWR_OFF) begin
        next_st.power = 1'b0;
      end else if (eff_power) begin
        case (cmd)
          CMD_PEAK:    next_st.peak = 1'b1;
          CMD_AVERAGE: next_st.peak = 1'b0;
          CMD_SC_ON:   next_st.sc   = 1'b1;
          CMD_SC_OFF:  next_st.sc   = 1'b0;
          default:     next_st.sc   = next_st.sc;
        endcase
      end
    end
    // Light mode override wins while held; latch follows the switch
    if (OVR_PEAK_I) begin
      next_st.peak = 1'b1;
    end else if (OVR_AVERAGE_I) begin
      next_st.peak = 1'b0;
    end
    // Power override moves the relay itself but never the subcarrier
    if (OVR_PWR_ON_I) begin
      next_st.power = 1'b1;
    end else if (OVR_PWR_OFF_I) begin
      next_st.power = 1'b0;
    end
    // Relay-unit mode bit written by software
    if (wr_access && PADDR_I == CTRL_OFS) begin
      next_st.tv_remote = PWDATA_I[0];
    end
    // Drive outputs; the supply dropout does not touch the latches
    next_st.cam_pwr = next_st.power;
    next_st.peak_o  = next_st.peak;
    next_st.sc_o    = next_st.sc;
    next_st.xmit    = next_st.power && next_st.tv_remote;
    for (int i = 0; i < NUM_AXES; i++) begin
      next_st.run[i] = (dir[i] != DIR_STOP);
      next_st.rev[i] = (dir[i] == DIR_REV);
    end
    // APB answer in the access phase, one cycle
    next_st.pready  = PSEL_I && !PENABLE_I;
    next_st.pslverr = PSEL_I && !PENABLE_I && !is_mapped(PADDR_I);
    next_st.prdata  = 32'h0000_0000;
    if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      case (PADDR_I)
        STATUS_OFS: begin
          next_st.prdata[ST_POWER] = st.power;
          next_st.prdata[ST_PEAK]  = st.peak;
          next_st.prdata[ST_SC]    = st.sc;
          next_st.prdata[ST_XMIT]  = st.xmit;
          for (int i = 0; i < NUM_AXES; i++) begin
            next_st.prdata[ST_AXIS + 2 * i +: 2] = dir[i];
          end
        end
        LIMIT_OFS: begin
          next_st.prdata[3:0]   = LIM_FWD_I;
          next_st.prdata[7:4]   = LIM_REV_I;
          next_st.prdata[8]     = OVR_PWR_ON_I;
          next_st.prdata[9]     = OVR_PWR_OFF_I;
          next_st.prdata[10]    = OVR_PEAK_I;
          next_st.prdata[11]    = OVR_AVERAGE_I;
          next_st.prdata[12]    = SUPPLY_OK_I;
        end
        CTRL_OFS:   next_st.prdata[0] = st.tv_remote;
        default:    next_st.prdata = 32'h0000_0000;
      endcase
    end
  end

  // Single register stage for all state
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st         <= '0;
      st.power   <= RST_POWER;
      st.peak    <= RST_PEAK;
      st.sc      <= RST_SC;
      st.peak_o  <= RST_PEAK;
      st.sc_o    <= RST_SC;
      st.cam_pwr <= RST_POWER;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs straight from flip-flops
  assign PRDATA_O          = st.prdata;
  assign PREADY_O          = st.pready;
  assign PSLVERR_O         = st.pslverr;
  assign MOTOR_RUN_O       = st.run;
  assign MOTOR_REV_O       = st.rev;
  assign CAMERA_POWER_O    = st.cam_pwr;
  assign PEAK_LIGHT_MODE_O = st.peak_o;
  assign SUBCARRIER_EN_O   = st.sc_o;
  assign XMIT_CTRL_O       = st.xmit;

  // ==========================================================================
  // Assertions
  a_pwr_on_sc: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    cmd_wr && cmd == CMD_PWR_ON |=> st.sc)
    else $error("power on did not set subcarrier");
  a_standby_ignore: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    cmd_wr && !eff_power && cmd == CMD_SC_OFF && !OVR_PWR_ON_I
    |=> st.sc == $past(st.sc))
    else $error("subcarrier changed in standby");
  a_ovr_no_sc: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    OVR_PWR_ON_I && !cmd_wr |=> st.power && st.sc == $past(st.sc))
    else $error("override touched subcarrier");
  a_ovr_peak: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    OVR_PEAK_I |=> PEAK_LIGHT_MODE_O)
    else $error("peak override not applied");
  a_no_run_off: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !motor_power |=> ##1 MOTOR_RUN_O == 4'h0)
    else $error("motor ran without power");
  a_supply_keep: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !SUPPLY_OK_I && !cmd_wr && !OVR_PWR_ON_I && !OVR_PWR_OFF_I
    |=> st.power == $past(st.power))
    else $error("latch lost on dropout");
  a_avg_cmd: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    cmd_wr && cmd == CMD_AVERAGE && eff_power && !OVR_PEAK_I
    |=> !st.peak)
    else $error("average mode not set");
  a_apb_ready: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("apb answer late");

  // Latch commands take effect at the access edge while powered
  a_peak_cmd: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    cmd_wr && cmd == CMD_PEAK && eff_power && !OVR_AVERAGE_I |=> st.peak)
    else $error("peak mode not set");
  a_sc_on_cmd: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    cmd_wr && cmd == CMD_SC_ON && eff_power |=> st.sc)
    else $error("subcarrier not set");
  a_sc_off_cmd: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    cmd_wr && cmd == CMD_SC_OFF && eff_power |=> !st.sc)
    else $error("subcarrier not cleared");
  a_pwr_off_cmd: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    cmd_wr && cmd == CMD_PWR_OFF && !OVR_PWR_ON_I |=> !st.power)
    else $error("power off not latched");

  // Held override ends force their latch; on beats off, peak beats average
  a_ovr_avg: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    OVR_AVERAGE_I && !OVR_PEAK_I |=> !st.peak)
    else $error("average override not applied");
  a_ovr_pwr_off: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    OVR_PWR_OFF_I && !OVR_PWR_ON_I |=> !st.power)
    else $error("power off override not applied");

  // Motors must not restart on their own when power comes back
  a_stay_stopped: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    $rose(motor_power) |=> MOTOR_RUN_O == 4'h0)
    else $error("axis restarted after power loss");

  // Unmapped places are refused, and only together with ready
  a_bad_addr: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    PSEL_I && !PENABLE_I && !is_mapped(PADDR_I) |=> PSLVERR_O)
    else $error("unmapped address not refused");
  a_err_ready: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    PSLVERR_O |-> PREADY_O)
    else $error("error without ready");

  c_two_axes: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    $countones(MOTOR_RUN_O) >= 2);
  c_pwr_cycle: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    CAMERA_POWER_O ##1 !CAMERA_POWER_O ##[1:20] CAMERA_POWER_O);
  c_override: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    OVR_PWR_ON_I && !st.sc);
  c_limit_hit: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    LIM_FWD_I != 4'h0);

endmodule : cam_cmd_decoder

`default_nettype wire

/* File: rtl/cam_cmd_pkg.sv */
/*
  Shared constants for the camera remote command decoder: APB register
  offsets, field positions, reset values, command codes and timing counts.
  Assumes a 250 MHz system clock.
*/
package cam_cmd_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CMD_OFS     = 8'h00;  // Write: command code
  localparam logic [7:0] STATUS_OFS  = 8'h04;  // Read: latches and axis state
  localparam logic [7:0] LIMIT_OFS   = 8'h08;  // Read: limit switches, override
  localparam logic [7:0] CTRL_OFS    = 8'h0C;  // R/W: relay-unit tv remote mode

  // ==========================================================================
  // Command codes (low five bits of a CMD write)
  localparam logic [4:0] CMD_NOP       = 5'h00;
  localparam logic [4:0] CMD_AXIS_BASE = 5'h01;  // 01..0C: axis*3 + op
  localparam logic [4:0] CMD_PEAK      = 5'h10;
  localparam logic [4:0] CMD_AVERAGE   = 5'h11;
  localparam logic [4:0] CMD_PWR_ON    = 5'h12;
  localparam logic [4:0] CMD_PWR_OFF   = 5'h13;
  localparam logic [4:0] CMD_SC_ON     = 5'h14;
  localparam logic [4:0] CMD_SC_OFF    = 5'h15;

  // Per axis operation index within a group of three
  localparam logic [1:0] OP_FWD  = 2'h0;
  localparam logic [1:0] OP_REV  = 2'h1;
  localparam logic [1:0] OP_STOP = 2'h2;

  // Axis count: pan, tilt, zoom, iris
  localparam int NUM_AXES = 4;
  localparam int AXIS_IRIS = 3;

  // ==========================================================================
  // Status field positions
  localparam int ST_POWER  = 0;
  localparam int ST_PEAK   = 1;
  localparam int ST_SC     = 2;
  localparam int ST_XMIT   = 3;
  localparam int ST_AXIS   = 8;   // 2 bits per axis from here

  // Reset values of the latches (held state lives in relays; these are the
  // values a fresh digital reset takes)
  localparam logic RST_POWER = 1'b0;
  localparam logic RST_PEAK  = 1'b1;
  localparam logic RST_SC    = 1'b1;

  // ==========================================================================
  // Timing: iris full travel bound and motor step rate
  localparam int  CLK_MHZ         = 250;
  localparam real IRIS_RANGE_DEG  = 123.0;
  localparam real IRIS_TIME_S     = 13.1;
  localparam longint IRIS_TRAVEL_CYC = longint'(IRIS_TIME_S * CLK_MHZ * 1.0e6);
  localparam int  STEP_HZ_DEFAULT = 1000;  // Plain stepping rate default

  // Axis run direction
  typedef enum logic [1:0] {
    DIR_STOP = 2'h0,
    DIR_FWD  = 2'h1,
    DIR_REV  = 2'h2
  } dir_t;

endpackage : cam_cmd_pkg

/* File: rtl/cam_axis.sv */
/*
  One motor axis of the camera command decoder: run direction state with
  limit-switch stop and inhibit, and power interlock.
  Assumes commands arrive as one-cycle pulses and limits are synchronous.
*/
`timescale 1ns/1ns
`default_nettype none

module cam_axis
  import cam_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Commands and interlocks
  input  wire logic fwd_i,
  input  wire logic rev_i,
  input  wire logic stop_i,
  input  wire logic power_i,
  input  wire logic lim_fwd_i,
  input  wire logic lim_rev_i,
  // State
  output var  dir_t dir_o
);

  typedef struct packed {
    dir_t dir;
  } axis_state_t;

  axis_state_t st;
  axis_state_t next_st;

  // ==========================================================================
  // Next direction: limits stop, further drive into a limit is refused
  always_comb begin
    next_st = st;
    if (fwd_i && !lim_fwd_i) begin
      next_st.dir = DIR_FWD;
    end else if (rev_i && !lim_rev_i) begin
      next_st.dir = DIR_REV;
    end else if (stop_i) begin
      next_st.dir = DIR_STOP;
    end
    if ((next_st.dir == DIR_FWD && lim_fwd_i) ||
        (next_st.dir == DIR_REV && lim_rev_i)) begin
      next_st.dir = DIR_STOP;
    end
    // Power off or a dropout always lands the axis stopped
    if (!power_i) begin
      next_st.dir = DIR_STOP;
    end
  end

  // Register; direction only moves on command, limit or power loss
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{dir: DIR_STOP};
    end else begin
      st <= next_st;
    end
  end

  assign dir_o = st.dir;

  // ==========================================================================
  a_limit_stops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    lim_fwd_i |=> st.dir != DIR_FWD)
    else $error("axis ran into forward limit");
  a_power_stops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !power_i |=> st.dir == DIR_STOP)
    else $error("axis ran without power");
  a_reverse_ok: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    power_i && rev_i && !fwd_i && !lim_rev_i |=> st.dir == DIR_REV)
    else $error("reverse command not taken");
  a_hold_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    power_i && !fwd_i && !rev_i && !stop_i && !lim_fwd_i && !lim_rev_i
    |=> st.dir == $past(st.dir))
    else $error("axis changed with no cause");
  c_reversal: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    st.dir == DIR_FWD ##1 st.dir == DIR_REV);

endmodule : cam_axis

`default_nettype wire

/* File: bench/cam_mech_model.sv */
/*
  Mechanics model for the camera command decoder: one position counter
  per axis follows the motor drives and raises the end limit switches.
  Assumes one step per clock while an axis runs; RANGE is kept short.
*/
`timescale 1ns/1ns
`default_nettype none

module cam_mech_model #(
  parameter int RANGE = 64  // Steps from one end limit to the other
) (
  // Clock
  input  wire logic       clk_i,
  // Motor drives
  input  wire logic [3:0] run_i,
  input  wire logic [3:0] rev_i,
  // Limit switches
  output logic      [3:0] lim_fwd_o,
  output logic      [3:0] lim_rev_o
);
  // ==========================================================================
  // Position
  int pos [4];

  // Mechanics keep their place across a digital reset, so no reset here
  initial begin
    for (int k = 0; k < 4; k++) pos[k] = RANGE / 2;
  end

  // Net run time in each direction gives the position
  always @(posedge clk_i) begin
    for (int k = 0; k < 4; k++) begin
      if (run_i[k] && !rev_i[k] && pos[k] < RANGE) pos[k] <= pos[k] + 1;
      if (run_i[k] && rev_i[k] && pos[k] > 0) pos[k] <= pos[k] - 1;
    end
  end

  // Clamped ends hold the switch while a late stop overshoots
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      lim_fwd_o[k] = (pos[k] >= RANGE);
      lim_rev_o[k] = (pos[k] <= 0);
    end
  end
endmodule : cam_mech_model

`default_nettype wire

/* File: bench/tb_camera_remote_command_decoder.sv */
/*
  Self-checking bench for the camera command decoder: a table of commands
  with expected outputs, then hand tests of registers, limits, dropout
  and overrides. Assumes the mechanics model drives the limit switches.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_camera_remote_command_decoder import cam_cmd_pkg::*;;
  // ==========================================================================
  // Signals
  logic        clk, rst_n, psel, penable, pwrite, supply_ok;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, pwr, peak, sc, xmit;
  logic [3:0]  lim_fwd, lim_rev, run, rev, ovr;  // ovr: on,off,peak,avg
  int          num_errors, n_checks;
  logic [31:0] outs;

  assign outs = {20'h0, xmit, run, rev, sc, peak, pwr};

  typedef struct packed {
    logic [4:0] cmd;
    logic [3:0] run;
    logic [3:0] rev;
    logic [2:0] lat;  // subcarrier, peak, power
  } row_t;

  // Standby first, then latches, then all twelve motor codes
  row_t rows [24] = '{
    '{5'h15, 4'h0, 4'h0, 3'b110}, '{5'h11, 4'h0, 4'h0, 3'b110},
    '{5'h01, 4'h0, 4'h0, 3'b110}, '{5'h12, 4'h0, 4'h0, 3'b111},
    '{5'h15, 4'h0, 4'h0, 3'b011}, '{5'h14, 4'h0, 4'h0, 3'b111},
    '{5'h15, 4'h0, 4'h0, 3'b011}, '{5'h11, 4'h0, 4'h0, 3'b001},
    '{5'h10, 4'h0, 4'h0, 3'b011}, '{5'h13, 4'h0, 4'h0, 3'b010},
    '{5'h12, 4'h0, 4'h0, 3'b111}, '{5'h01, 4'h1, 4'h0, 3'b111},
    '{5'h02, 4'h1, 4'h1, 3'b111}, '{5'h04, 4'h3, 4'h1, 3'b111},
    '{5'h03, 4'h2, 4'h0, 3'b111}, '{5'h05, 4'h2, 4'h2, 3'b111},
    '{5'h06, 4'h0, 4'h0, 3'b111}, '{5'h07, 4'h4, 4'h0, 3'b111},
    '{5'h08, 4'h4, 4'h4, 3'b111}, '{5'h09, 4'h0, 4'h0, 3'b111},
    '{5'h0A, 4'h8, 4'h0, 3'b111}, '{5'h0B, 4'h8, 4'h8, 3'b111},
    '{5'h0C, 4'h0, 4'h0, 3'b111}, '{5'h00, 4'h0, 4'h0, 3'b111}};

  // ==========================================================================
  // Design and mechanics
  cam_cmd_decoder uut (
    .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .LIM_FWD_I(lim_fwd), .LIM_REV_I(lim_rev), .SUPPLY_OK_I(supply_ok),
    .OVR_PWR_ON_I(ovr[0]), .OVR_PWR_OFF_I(ovr[1]), .OVR_PEAK_I(ovr[2]),
    .OVR_AVERAGE_I(ovr[3]), .MOTOR_RUN_O(run), .MOTOR_REV_O(rev),
    .CAMERA_POWER_O(pwr), .PEAK_LIGHT_MODE_O(peak),
    .SUBCARRIER_EN_O(sc), .XMIT_CTRL_O(xmit));

  cam_mech_model #(.RANGE(64)) mech (
    .clk_i(clk), .run_i(run), .rev_i(rev),
    .lim_fwd_o(lim_fwd), .lim_rev_o(lim_rev));

  // ==========================================================================
  // Tasks
  task automatic finish_test();
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Values sampled straight after the edge are those the edge saw
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      num_errors++;
      finish_test();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Motors settle one edge after the access edge
  task automatic cmd(input logic [4:0] c);
    apb(1'b1, CMD_OFS, {27'h0, c});
    repeat (3) @(posedge clk);
  endtask : cmd

  task automatic wait_stop(input int ax);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (run[ax] === 1'b0) break;
    end
    if (i == 200) begin
      num_errors++;
      finish_test();
    end
  endtask : wait_stop

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #400000;
    num_errors++;
    finish_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    supply_ok = 1'b1;
    ovr = 4'h0;
    num_errors = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    chk("reset outputs", outs, 32'h6);
    rst_n <= 1'b1;
    // Quiet gap before the first command, a scaled lock time
    repeat (4) @(posedge clk);
    foreach (rows[k]) begin
      cmd(rows[k].cmd);
      chk("outputs", outs, {21'h0, rows[k].run, rows[k].rev, rows[k].lat});
    end
    // Registers, transmitter line and an unmapped place
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", rd & 32'hF, 32'h7);
    apb(1'b1, CTRL_OFS, 32'h1);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h1);
    repeat (2) @(posedge clk);
    chk("xmit on", {31'h0, xmit}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    cmd(CMD_PWR_OFF);
    chk("xmit off", {31'h0, xmit}, 32'h0);
    cmd(CMD_PWR_ON);
    repeat (4) @(posedge clk);
    // Iris into its forward limit, then pushed further, then reversed
    cmd(5'h0A);
    wait_stop(AXIS_IRIS);
    repeat (2) @(posedge clk);
    chk("iris limit", {24'h0, lim_fwd, run}, 32'h80);
    apb(1'b0, LIMIT_OFS, 32'h0);
    chk("limit reg", rd, 32'h1008);
    chk("limit err", {31'h0, err}, 32'h0);
    cmd(5'h0A);
    chk("iris inhibited", {28'h0, run}, 32'h0);
    cmd(5'h0B);
    chk("iris reversed", {24'h0, run, rev}, 32'h88);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("iris dir", {30'h0, rd[ST_AXIS+2*AXIS_IRIS +: 2]}, 32'(DIR_REV));
    wait_stop(AXIS_IRIS);
    chk("iris rev limit", {31'h0, lim_rev[3]}, 32'h1);
    // Two axes only while dropping the supply
    cmd(5'h01);
    cmd(5'h04);
    supply_ok <= 1'b0;
    repeat (2) @(posedge clk);
    supply_ok <= 1'b1;
    repeat (3) @(posedge clk);
    chk("after dropout", outs, 32'h807);
    cmd(5'h02);
    chk("runs again", {28'h0, run}, 32'h1);
    cmd(CMD_PWR_OFF);
    chk("power off", {28'h0, run}, 32'h0);
    // Overrides
    cmd(CMD_PWR_ON);
    cmd(CMD_SC_OFF);
    cmd(CMD_PWR_OFF);
    ovr <= 4'h1;
    repeat (3) @(posedge clk);
    chk("ovr on", {29'h0, sc, peak, pwr}, 32'h3);
    ovr <= 4'h0;
    repeat (3) @(posedge clk);
    chk("ovr release", {31'h0, pwr}, 32'h1);
    ovr <= 4'h2;
    cmd(CMD_PWR_ON);
    chk("ovr off", {31'h0, pwr}, 32'h0);
    ovr <= 4'h0;
    cmd(CMD_PWR_ON);
    chk("cmd on", {29'h0, sc, peak, pwr}, 32'h7);
    ovr <= 4'h8;
    cmd(CMD_PEAK);
    chk("ovr avg", {31'h0, peak}, 32'h0);
    ovr <= 4'h0;
    cmd(CMD_PEAK);
    chk("cmd peak", {31'h0, peak}, 32'h1);
    ovr <= 4'h4;
    cmd(CMD_AVERAGE);
    chk("ovr peak", {31'h0, peak}, 32'h1);
    ovr <= 4'h0;
    cmd(CMD_AVERAGE);
    chk("cmd avg", {31'h0, peak}, 32'h0);
    finish_test();
  end
endmodule : tb_camera_remote_command_decoder

`default_nettype wire
